/* dv/bit_processor_command_dispatch_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module bit_processor_command_dispatch_bench;
  import bpcd_pkg::*;
  logic clock_i, rst_n_i, mem_rd_o, mem_valid_i, io_req_o, io_wr_o, io_wdata_o;
  logic io_ack_i, io_err_i, io_rdata_i, word_req_o, word_done_i, word_err_i, jump_i;
  logic irq_line_i, handler_start_o, irq_clear_i, rlo_o, fail, jump_en;
  logic [ADDR_W-1:0]   mem_addr_o, pc_o, jump_target_i, jump_to, ret_addr;
  logic [UCMD_W-1:0]   mem_data_i;
  logic [PAR_W-1:0]    io_addr_o, word_param_o;
  logic [7:0]          word_entry_o, handler_block_o;
  logic [IRQ_EV_W-1:0] irq_events_o;
  logic [3:0]          delay;
  logic [8:0]          wr_log [$];
  logic [15:0]         wd_log [$];
  int                  bad_count, n_compared, starts;

  bpcd_dispatch dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_data_i(mem_data_i), .mem_valid_i(mem_valid_i),
    .io_req_o(io_req_o), .io_wr_o(io_wr_o), .io_addr_o(io_addr_o), .io_wdata_o(io_wdata_o),
    .io_ack_i(io_ack_i), .io_err_i(io_err_i), .io_rdata_i(io_rdata_i),
    .word_req_o(word_req_o), .word_entry_o(word_entry_o), .word_param_o(word_param_o),
    .word_done_i(word_done_i), .word_err_i(word_err_i), .pc_o(pc_o), .jump_i(jump_i),
    .jump_target_i(jump_target_i), .irq_line_i(irq_line_i),
    .handler_start_o(handler_start_o), .handler_block_o(handler_block_o),
    .irq_events_o(irq_events_o), .irq_clear_i(irq_clear_i), .rlo_o(rlo_o));

  bpcd_partner_model partner_u (.clock_i(clock_i), .mem_addr_i(mem_addr_o),
    .mem_rd_i(mem_rd_o), .mem_data_o(mem_data_i), .mem_valid_o(mem_valid_i),
    .io_req_i(io_req_o), .io_wr_i(io_wr_o), .io_addr_i(io_addr_o), .io_wdata_i(io_wdata_o),
    .io_ack_o(io_ack_i), .io_err_o(io_err_i), .io_rdata_o(io_rdata_i),
    .word_req_i(word_req_o), .pc_i(pc_o), .word_done_o(word_done_i),
    .word_err_o(word_err_i), .jump_o(jump_i), .jump_target_o(jump_target_i),
    .delay_i(delay), .fail_i(fail), .jump_en_i(jump_en), .jump_to_i(jump_to),
    .ret_addr_o(ret_addr));

  // ***********************
  // Clock and bus monitors
  // ***********************
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    if (io_req_o && io_ack_i && io_wr_o)
      wr_log.push_back({io_wdata_o, io_addr_o});
    if (word_req_o && word_done_i)
      wd_log.push_back({word_entry_o, word_param_o});
    if (handler_start_o)
      starts++;
  end

  // ***********************
  // Shared tasks
  // ***********************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
  begin
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  end
  endtask : check

  task automatic wrap_up();
  begin
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask : wrap_up

  task automatic wait_pc(input logic [ADDR_W-1:0] where);
    int n;
  begin
    n = 0;
    while (pc_o !== where && n < 3000)
    begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 3000)
    begin
      bad_count++;
      $display("unexpected timeout waiting for pc %h", where);
      wrap_up();
    end
  end
  endtask : wait_pc

  // Program is loaded while the design sits in reset, so no fetch sees a half-written store
  task automatic restart(input logic [15:0] prog [$]);
  begin
    @(negedge clock_i);
    rst_n_i = 1'b0;
    for (int i = 0; i < 32768; i++)
      partner_u.mem[i] = (i < prog.size()) ? prog[i] : 16'h0000;
    wr_log.delete();
    wd_log.delete();
    repeat (2) @(negedge clock_i);
    rst_n_i = 1'b1;
  end
  endtask : restart

  // ***********************
  // Scenarios
  // ***********************
  task automatic sc_reset();
  begin
    check("pc", pc_o, 0);
    check("block", handler_block_o, HANDLER_BLOCK);
    check("reqs", {mem_rd_o, io_req_o, word_req_o, handler_start_o}, 0);
    check("events", irq_events_o, 0);
  end
  endtask : sc_reset

  task automatic sc_bits();
  begin
    partner_u.io_bits[1] = 1'b1;
    partner_u.io_bits[2] = 1'b1;
    restart('{16'h2001, 16'h1002, 16'h7010, 16'h3002, 16'h7011, 16'h2001, 16'h5012,
              16'h6013, 16'h2003, 16'h9000, 16'h4003, 16'ha000});
    wait_pc(15'h0008);
    check("address", mem_addr_o, 15'h0008);
    check("rlo or", rlo_o, 1);
    // OR bracket around a negated OR: 0 OR (NOT 0) gives 1
    wait_pc(15'h000c);
    check("rlo bracket", rlo_o, 1);
    repeat (4) @(negedge clock_i);
    check("writes", wr_log.size(), 4);
    if (wr_log.size() == 4)
    begin
      check("assign hi", wr_log[0], 9'h110);
      check("assign lo", wr_log[1], 9'h011);
      check("set", wr_log[2], 9'h112);
      check("reset", wr_log[3], 9'h013);
    end
    check("no word", wd_log.size(), 0);
  end
  endtask : sc_bits

  task automatic sc_brackets();
  begin
    restart('{16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000,
              16'h8000, 16'ha000});
    wait_pc(15'h0007);
    check("seven deep", irq_events_o[EV_NEST_ERR], 0);
    wait_pc(15'h0009);
    check("eighth open", irq_events_o[EV_NEST_ERR], 1);
    irq_clear_i = 1'b1;
    @(negedge clock_i);
    irq_clear_i = 1'b0;
    @(negedge clock_i);
    check("cleared", irq_events_o, 0);
  end
  endtask : sc_brackets

  task automatic sc_words();
  begin
    delay   = 4'h3;
    jump_en = 1'b0;
    restart('{16'hb5a7, 16'hc133});
    wait_pc(15'h0001);
    check("word step", wd_log.size(), 1);
    jump_en = 1'b1;
    wait_pc(15'h0100);
    check("words", wd_log.size(), 2);
    if (wd_log.size() == 2)
    begin
      check("entry b", wd_log[0], {WORD_BASE + 8'h0b, 8'ha7});
      check("entry c", wd_log[1], {WORD_BASE + 8'h0c, 8'h33});
    end
    check("return", ret_addr, 15'h0001);
    jump_en = 1'b0;
    delay   = 4'h0;
  end
  endtask : sc_words

  task automatic sc_errors();
  begin
    fail = 1'b1;
    restart('{16'h2005, 16'he000});
    wait_pc(15'h0002);
    @(negedge clock_i);
    check("io err", irq_events_o[EV_IO_ERR], 1);
    check("word err", irq_events_o[EV_WORD_ERR], 1);
    fail = 1'b0;
  end
  endtask : sc_errors

  task automatic sc_irq();
    int n;
  begin
    restart('{16'h0000});
    starts = 0;
    repeat (3) @(negedge clock_i);
    for (int k = 1; k <= 2; k++)
    begin
      irq_line_i = 1'b1;
      n = 0;
      while (starts < k && n < 50)
      begin
        @(negedge clock_i);
        n++;
      end
      check("line event", irq_events_o[EV_LINE], 1);
      repeat (20) @(negedge clock_i);
      check("one start", starts, k);
      check("block", handler_block_o, 8'h02);
      irq_line_i  = 1'b0;
      irq_clear_i = 1'b1;
      repeat (3) @(negedge clock_i);
      irq_clear_i = 1'b0;
      repeat (3) @(negedge clock_i);
    end
  end
  endtask : sc_irq

  initial
  begin
    {rst_n_i, irq_line_i, irq_clear_i, fail, jump_en} = '0;
    {bad_count, n_compared, starts} = '0;
    delay   = 4'h0;
    jump_to = 15'h0100;
    repeat (20) @(negedge clock_i);
    sc_reset();
    rst_n_i = 1'b1;
    sc_bits();
    sc_brackets();
    sc_words();
    sc_errors();
    sc_irq();
    wrap_up();
  end
endmodule : bit_processor_command_dispatch_bench
`default_nettype wire

/* dv/bpcd_partner_model.sv */
`timescale 1ns/100ps
`default_nettype none
module bpcd_partner_model
  import bpcd_pkg::*;
(
  input  wire logic                        clock_i,
  input  wire logic [bpcd_pkg::ADDR_W-1:0] mem_addr_i,
  input  wire logic                        mem_rd_i,
  output logic [bpcd_pkg::UCMD_W-1:0]      mem_data_o,
  output logic                             mem_valid_o,
  input  wire logic                        io_req_i,
  input  wire logic                        io_wr_i,
  input  wire logic [bpcd_pkg::PAR_W-1:0]  io_addr_i,
  input  wire logic                        io_wdata_i,
  output logic                             io_ack_o,
  output logic                             io_err_o,
  output logic                             io_rdata_o,
  input  wire logic                        word_req_i,
  input  wire logic [bpcd_pkg::ADDR_W-1:0] pc_i,
  output logic                             word_done_o,
  output logic                             word_err_o,
  output logic                             jump_o,
  output logic [bpcd_pkg::ADDR_W-1:0]      jump_target_o,
  input  wire logic [3:0]                  delay_i,
  input  wire logic                        fail_i,
  input  wire logic                        jump_en_i,
  input  wire logic [bpcd_pkg::ADDR_W-1:0] jump_to_i,
  output logic [bpcd_pkg::ADDR_W-1:0]      ret_addr_o
);
  // ***********************
  // Storage and handshakes
  // ***********************
  logic [UCMD_W-1:0] mem [0:32767];
  logic [255:0]      io_bits;
  logic [3:0]        cnt;
  logic              answered;
  initial
  begin
    {io_ack_o, io_err_o, word_done_o, word_err_o, jump_o} = '0;
    {io_rdata_o, jump_target_o, ret_addr_o, cnt, answered, io_bits} = '0;
  end
  // The fetch strobe stands one cycle only, so the store answers within that cycle
  assign mem_valid_o = mem_rd_i;
  assign mem_data_o  = mem_rd_i ? mem[mem_addr_i] : ~mem[mem_addr_i];
  // Stale lines are inverted so that nothing can lean on a held value
  always @(posedge clock_i)
  begin
    {io_ack_o, io_err_o, word_done_o, word_err_o, jump_o} <= '0;
    io_rdata_o    <= ~io_rdata_o;
    jump_target_o <= ~jump_target_o;
    if (!io_req_i && !word_req_i)
    begin
      cnt      <= delay_i;
      answered <= 1'b0;
    end
    else if (!answered && cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (!answered)
    begin
      answered <= 1'b1;
      if (io_req_i)
      begin
        io_ack_o   <= !fail_i;
        io_err_o   <= fail_i;
        io_rdata_o <= io_bits[io_addr_i];
        if (io_wr_i && !fail_i)
          io_bits[io_addr_i] <= io_wdata_i;
      end
      else
      begin
        ret_addr_o    <= pc_i;
        word_done_o   <= 1'b1;
        word_err_o    <= fail_i;
        jump_o        <= jump_en_i;
        jump_target_o <= jump_to_i;
      end
    end
  end
endmodule : bpcd_partner_model
`default_nettype wire

/* logic/bpcd_bracket_stack.sv */
`timescale 1ns/100ps
`default_nettype none
module bpcd_bracket_stack
  import bpcd_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic               rst_n_i,
  input  wire logic               push_i,
  input  wire logic               pop_i,
  input  wire logic [1:0]         push_val_i,
  output logic [1:0]              top_o,
  output logic [DEPTH_W-1:0]      depth_o
);
  // Each level keeps the saved result and the combining operation (1 = OR)
  logic [1:0]         mem_reg  [BRACKET_MAX];
  logic [1:0]         mem_next [BRACKET_MAX];
  logic [DEPTH_W-1:0] depth_reg;
  logic [DEPTH_W-1:0] depth_next;

  always_comb
  begin
    mem_next   = mem_reg;
    depth_next = depth_reg;
    if (push_i && depth_reg != DEPTH_W'(BRACKET_MAX))
    begin
      mem_next[depth_reg] = push_val_i;
      depth_next          = depth_reg + DEPTH_ONE;
    end
    else if (pop_i && depth_reg != '0)
      depth_next = depth_reg - DEPTH_ONE;
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      depth_reg <= '0;
      for (int i = 0; i < BRACKET_MAX; i++)
        mem_reg[i] <= 2'h0;
    end
    else
    begin
      depth_reg <= depth_next;
      mem_reg   <= mem_next;
    end
  end

  assign top_o   = (depth_reg == '0) ? 2'h0 : mem_reg[depth_reg - DEPTH_ONE];
  assign depth_o = depth_reg;

  AST_DEPTH_MAX: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    depth_reg <= DEPTH_W'(BRACKET_MAX)) else $error("bracket depth beyond seven");
endmodule : bpcd_bracket_stack
`default_nettype wire

/* logic/bpcd_decode_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface bpcd_decode_if;
  import bpcd_pkg::*;
  logic [OPC_W-1:0] opcode;
  logic [UPC_W-1:0] entry;
  logic             is_word;
  logic [7:0]       word_entry;
  modport table_side (input opcode, output entry, output is_word, output word_entry);
  modport user_side  (output opcode, input entry, input is_word, input word_entry);
endinterface : bpcd_decode_if
`default_nettype wire

/* logic/bpcd_dispatch.sv */
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Fetch each command; run bit commands here, hand word commands to byte processor.
// - Command register splits every fetched command into opcode and parameter.
// - Opcode entry table gives sequencer entry; sequencer issues execution control.
// - Word command entry table gives the byte processor its routine entry.
// - Logic unit does logic, set and reset, with seven bracket levels.
// - Address counter advances under sequencer and points at current command.
// - On jumps byte processor reads counter as return, then loads target.
// - Interrupt register records every interrupting event except clock stoppage.
// - All user I/O accesses go through the bit processor.
// - Interrupt line starts interrupt handler block 2; cyclic run resumes next cycle without waiting for it.
// - User memory is 16-bit words, up to 32 x 1024 words.
// - One clock drives both processors.
module bpcd_dispatch
  import bpcd_pkg::*;
(
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  // User memory
  output logic [bpcd_pkg::ADDR_W-1:0] mem_addr_o,
  output logic                      mem_rd_o,
  input  wire logic [bpcd_pkg::UCMD_W-1:0] mem_data_i,
  input  wire logic                 mem_valid_i,
  // Peripheral bus
  output logic                      io_req_o,
  output logic                      io_wr_o,
  output logic [bpcd_pkg::PAR_W-1:0] io_addr_o,
  output logic                      io_wdata_o,
  input  wire logic                 io_ack_i,
  input  wire logic                 io_err_i,
  input  wire logic                 io_rdata_i,
  // Byte processor side
  output logic                      word_req_o,
  output logic [7:0]                word_entry_o,
  output logic [bpcd_pkg::PAR_W-1:0] word_param_o,
  input  wire logic                 word_done_i,
  input  wire logic                 word_err_i,
  output logic [bpcd_pkg::ADDR_W-1:0] pc_o,
  input  wire logic                 jump_i,
  input  wire logic [bpcd_pkg::ADDR_W-1:0] jump_target_i,
  // Interrupts
  input  wire logic                 irq_line_i,
  output logic                      handler_start_o,
  output logic [7:0]                handler_block_o,
  output logic [bpcd_pkg::IRQ_EV_W-1:0] irq_events_o,
  input  wire logic                 irq_clear_i,
  output logic                      rlo_o
);
  import bpcd_pkg::*;

  // ****************************************
  // State
  // ****************************************
  bpcd_state_t               state_reg, state_next;
  logic [ADDR_W-1:0]         pc_reg, pc_next;
  logic [OPC_W-1:0]          opc_reg, opc_next;
  logic [PAR_W-1:0]          par_reg, par_next;
  logic                      rlo_reg, rlo_next;
  logic                      first_reg, first_next;
  logic [IRQ_EV_W-1:0]       ev_reg, ev_next;
  logic                      rd_reg, rd_next;
  logic                      ioreq_reg, ioreq_next;
  logic                      iowr_reg, iowr_next;
  logic                      iowd_reg, iowd_next;
  logic                      wreq_reg, wreq_next;
  logic [7:0]                went_reg, went_next;
  logic                      hstart_reg, hstart_next;
  logic                      in_irq_reg, in_irq_next;
  logic                      push, pop;
  logic [1:0]                push_val, stk_top;
  logic [DEPTH_W-1:0]        depth;
  logic                      operand;
  logic                      comb_res;

  bpcd_decode_if dec ();
  assign dec.opcode = opc_reg;

  bpcd_entry_tables u_tables (.dec(dec));

  bpcd_bracket_stack u_stack (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_i),
    .push_i     (push),
    .pop_i      (pop),
    .push_val_i (push_val),
    .top_o      (stk_top),
    .depth_o    (depth)
  );

  // ****************************************
  // Logic unit
  // ****************************************
  always_comb
  begin
    operand = io_rdata_i ^ (opc_reg[7:4] == CL_ANDN || opc_reg[7:4] == CL_ORN);
    if (first_reg)
      comb_res = operand;
    else if (opc_reg[7:4] == CL_OR || opc_reg[7:4] == CL_ORN)
      comb_res = rlo_reg | operand;
    else
      comb_res = rlo_reg & operand;
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    state_next  = state_reg;
    pc_next     = pc_reg;
    opc_next    = opc_reg;
    par_next    = par_reg;
    rlo_next    = rlo_reg;
    first_next  = first_reg;
    rd_next     = 1'b0;
    ioreq_next  = ioreq_reg;
    iowr_next   = iowr_reg;
    iowd_next   = iowd_reg;
    wreq_next   = wreq_reg;
    went_next   = went_reg;
    hstart_next = 1'b0;
    in_irq_next = in_irq_reg;
    push        = 1'b0;
    pop         = 1'b0;
    push_val    = {opc_reg[7:4] == CL_OPENO, rlo_reg};
    // Hardware set wins over software clear
    ev_next     = irq_clear_i ? '0 : ev_reg;
    if (!irq_line_i)
      in_irq_next = 1'b0;
    case (state_reg)
      BPCD_FETCH:
      begin
        if (irq_line_i && !in_irq_reg)
        begin
          state_next  = BPCD_IRQ;
          ev_next[EV_LINE] = 1'b1;
        end
        else if (mem_valid_i && rd_reg)
        begin
          opc_next   = mem_data_i[UCMD_W-1:OPC_LSB];
          par_next   = mem_data_i[PAR_W-1:0];
          state_next = BPCD_EXEC;
        end
        else
          rd_next = !rd_reg;
      end
      BPCD_EXEC:
      begin
        state_next = BPCD_FETCH;
        pc_next    = pc_reg + PC_STEP;
        case (dec.entry)
          UE_LOGIC, UE_WRITE:
          begin
            // Peripheral traffic always goes through this path
            ioreq_next = 1'b1;
            iowr_next  = (dec.entry == UE_WRITE);
            iowd_next  = (opc_reg[7:4] == CL_SET) ? 1'b1 :
                         (opc_reg[7:4] == CL_RESET) ? 1'b0 : rlo_reg;
            pc_next    = pc_reg;
            state_next = BPCD_IOWAIT;
          end
          UE_OPEN:
          begin
            if (depth == DEPTH_W'(BRACKET_MAX))
              ev_next[EV_NEST_ERR] = 1'b1;
            push       = 1'b1;
            first_next = 1'b1;
          end
          UE_CLOSE:
          begin
            pop      = 1'b1;
            rlo_next = stk_top[1] ? (stk_top[0] | rlo_reg) : (stk_top[0] & rlo_reg);
            first_next = 1'b0;
          end
          UE_WORD:
          begin
            wreq_next  = 1'b1;
            went_next  = dec.word_entry;
            pc_next    = pc_reg;
            state_next = BPCD_WORD;
          end
          default: ;
        endcase
      end
      BPCD_IOWAIT:
      begin
        if (io_ack_i || io_err_i)
        begin
          ioreq_next = 1'b0;
          state_next = BPCD_FETCH;
          pc_next    = pc_reg + PC_STEP;
          if (io_err_i)
            ev_next[EV_IO_ERR] = 1'b1;
          else if (!iowr_reg)
          begin
            rlo_next   = comb_res;
            first_next = 1'b0;
          end
          else
            first_next = 1'b1;
        end
      end
      BPCD_WORD:
      begin
        if (word_done_i)
        begin
          wreq_next  = 1'b0;
          state_next = BPCD_FETCH;
          // Byte processor has read pc_o as the return address before jumping
          pc_next    = jump_i ? jump_target_i : pc_reg + PC_STEP;
          if (word_err_i)
            ev_next[EV_WORD_ERR] = 1'b1;
        end
      end
      BPCD_IRQ:
      begin
        // Cyclic flow resumes from the unchanged counter in the next cycle, without waiting for the handler
        hstart_next = 1'b1;
        in_irq_next = 1'b1;
        state_next  = BPCD_FETCH;
      end
      default: state_next = BPCD_FETCH;
    endcase
  end

  // Bit path and byte processor share this single clock, so the handshakes need no sync
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg  <= BPCD_FETCH;
      pc_reg     <= PC_RESET;
      opc_reg    <= '0;
      par_reg    <= '0;
      rlo_reg    <= 1'b0;
      first_reg  <= 1'b1;
      ev_reg     <= '0;
      rd_reg     <= 1'b0;
      ioreq_reg  <= 1'b0;
      iowr_reg   <= 1'b0;
      iowd_reg   <= 1'b0;
      wreq_reg   <= 1'b0;
      went_reg   <= '0;
      hstart_reg <= 1'b0;
      in_irq_reg <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      pc_reg     <= pc_next;
      opc_reg    <= opc_next;
      par_reg    <= par_next;
      rlo_reg    <= rlo_next;
      first_reg  <= first_next;
      ev_reg     <= ev_next;
      rd_reg     <= rd_next;
      ioreq_reg  <= ioreq_next;
      iowr_reg   <= iowr_next;
      iowd_reg   <= iowd_next;
      wreq_reg   <= wreq_next;
      went_reg   <= went_next;
      hstart_reg <= hstart_next;
      in_irq_reg <= in_irq_next;
    end
  end

  assign mem_addr_o      = pc_reg;
  assign mem_rd_o        = rd_reg;
  assign io_req_o        = ioreq_reg;
  assign io_wr_o         = iowr_reg;
  assign io_addr_o       = par_reg;
  assign io_wdata_o      = iowd_reg;
  assign word_req_o      = wreq_reg;
  assign word_entry_o    = went_reg;
  assign word_param_o    = par_reg;
  assign pc_o            = pc_reg;
  assign handler_start_o = hstart_reg;
  assign handler_block_o = HANDLER_BLOCK;
  assign irq_events_o    = ev_reg;
  assign rlo_o           = rlo_reg;

  // ****************************************
  // Checks
  // ****************************************
  AST_STEP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state_reg == BPCD_WORD && word_done_i && !jump_i) |=> pc_reg == $past(pc_reg) + PC_STEP)
    else $error("counter did not step");
  AST_JUMP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state_reg == BPCD_WORD && word_done_i && jump_i) |=> pc_reg == $past(jump_target_i))
    else $error("jump target not loaded");
  AST_WORD_HANDOFF: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state_reg == BPCD_EXEC && dec.is_word) |=> word_req_o && word_entry_o == $past(dec.word_entry))
    else $error("word command not handed over");
  AST_SPLIT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state_reg == BPCD_FETCH && rd_reg && mem_valid_i && !irq_line_i) |=>
      opc_reg == $past(mem_data_i[15:8]) && par_reg == $past(mem_data_i[7:0]))
    else $error("command split wrong");
  AST_IRQ: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state_reg == BPCD_FETCH && irq_line_i && !in_irq_reg) |=> ##1 handler_start_o)
    else $error("handler block not started");
  AST_EVENT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state_reg == BPCD_IOWAIT && io_err_i) |=> irq_events_o[EV_IO_ERR])
    else $error("interrupt event lost");
  AST_IO_PATH: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state_reg == BPCD_EXEC && (dec.entry == UE_LOGIC || dec.entry == UE_WRITE)) |=>
      io_req_o && !word_req_o)
    else $error("peripheral access not via bit path");
  AST_SET: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state_reg == BPCD_EXEC && opc_reg[7:4] == CL_SET) |=> io_wr_o && io_wdata_o)
    else $error("set command wrong");
  AST_PC_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state_reg == BPCD_IOWAIT && !io_ack_i && !io_err_i) |=> $stable(pc_reg))
    else $error("counter left current command");
  AST_BIT_LOCAL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state_reg == BPCD_EXEC && !dec.is_word) |=> !word_req_o)
    else $error("bit command sent to byte processor");
endmodule : bpcd_dispatch
`default_nettype wire

/* logic/bpcd_entry_tables.sv */
`timescale 1ns/100ps
`default_nettype none
module bpcd_entry_tables
  import bpcd_pkg::*;
(
  bpcd_decode_if.table_side dec
);
  // ****************************************
  // Opcode and word command entry tables
  // ****************************************
  always_comb
  begin
    dec.is_word    = 1'b0;
    dec.word_entry = 8'h00;
    case (dec.opcode[7:4])
      CL_AND, CL_OR, CL_ANDN, CL_ORN: dec.entry = UE_LOGIC;
      CL_SET, CL_RESET, CL_ASSGN:     dec.entry = UE_WRITE;
      CL_OPENA, CL_OPENO:             dec.entry = UE_OPEN;
      CL_CLOSE:                       dec.entry = UE_CLOSE;
      CL_NOP:                         dec.entry = UE_NOP;
      default:
      begin
        // Any other class is a word command for the byte processor
        dec.entry      = UE_WORD;
        dec.is_word    = 1'b1;
        dec.word_entry = WORD_BASE + {4'h0, dec.opcode[7:4]};
      end
    endcase
  end
endmodule : bpcd_entry_tables
`default_nettype wire

/* logic/bpcd_pkg.sv */
package bpcd_pkg;
  // Memory geometry: 32 x 1024 words of 16 bits
  localparam int UCMD_W      = 16;
  localparam int ADDR_W      = 15;
  localparam int OPC_W       = 8;
  localparam int PAR_W       = 8;
  localparam int OPC_LSB     = 8;
  localparam int UPC_W       = 4;
  localparam int BRACKET_MAX = 7;
  localparam int DEPTH_W     = 3;
  localparam int IRQ_EV_W    = 4;
  // Interrupt event bit positions
  localparam int EV_LINE     = 0;
  localparam int EV_IO_ERR   = 1;
  localparam int EV_NEST_ERR = 2;
  localparam int EV_WORD_ERR = 3;
  localparam logic [ADDR_W-1:0] PC_RESET = 15'h0000;
  localparam logic [ADDR_W-1:0] PC_STEP  = 15'h0001;
  localparam logic [7:0] HANDLER_BLOCK   = 8'h02;
  localparam logic [DEPTH_W-1:0] DEPTH_ONE = 3'h1;
  // Bit opcode classes (upper nibble of opcode)
  localparam logic [3:0] CL_AND   = 4'h1;
  localparam logic [3:0] CL_OR    = 4'h2;
  localparam logic [3:0] CL_ANDN  = 4'h3;
  localparam logic [3:0] CL_ORN   = 4'h4;
  localparam logic [3:0] CL_SET   = 4'h5;
  localparam logic [3:0] CL_RESET = 4'h6;
  localparam logic [3:0] CL_ASSGN = 4'h7;
  localparam logic [3:0] CL_OPENA = 4'h8;
  localparam logic [3:0] CL_OPENO = 4'h9;
  localparam logic [3:0] CL_CLOSE = 4'ha;
  localparam logic [3:0] CL_NOP   = 4'h0;
  // Microprogram entry points
  localparam logic [UPC_W-1:0] UE_LOGIC = 4'h1;
  localparam logic [UPC_W-1:0] UE_WRITE = 4'h2;
  localparam logic [UPC_W-1:0] UE_OPEN  = 4'h3;
  localparam logic [UPC_W-1:0] UE_CLOSE = 4'h4;
  localparam logic [UPC_W-1:0] UE_WORD  = 4'h5;
  localparam logic [UPC_W-1:0] UE_NOP   = 4'h0;
  localparam logic [7:0] WORD_BASE = 8'h40;
  typedef enum {BPCD_FETCH, BPCD_EXEC, BPCD_IOWAIT, BPCD_WORD, BPCD_IRQ} bpcd_state_t;
endpackage : bpcd_pkg
